// File: logic/rtcsp_pkg.sv
package rtcsp_pkg;

    // Bus address of this slave; the value is arbitrary
    localparam logic [6:0] OWN_ADDR   = 7'h2A;
    localparam logic       DIR_READ   = 1'b1;
    localparam int         PTR_W      = 6;
    localparam logic [5:0] PTR_FIRST  = 6'h00;
    localparam logic [5:0] PTR_LAST   = 6'h3F;
    localparam logic [3:0] BIT_FIRST  = 4'h0;
    localparam logic [3:0] BIT_ACK    = 4'h8;
    localparam logic [3:0] BIT_END    = 4'h9;
    localparam int         FILT_DEF   = 4;
    localparam int         FILT_MAXC  = 15;
    localparam int         PIN_SCL    = 0;
    localparam int         PIN_SDA    = 1;
    localparam int         PIN_COUNT  = 2;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } rtcsp_wr_t;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } rtcsp_state_t;

endpackage

// File: logic/rtcsp_slave.sv
`timescale 1ns/1ns
`default_nettype none

module rtcsp_slave #(
    parameter int FILT_LEN = rtcsp_pkg::FILT_DEF
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    link_clk,
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe,
    output logic                         wr_valid,
    output rtcsp_pkg::rtcsp_wr_t         wr_evt,
    output logic                         rd_req,
    output logic [rtcsp_pkg::PTR_W-1:0]  rd_addr,
    input  wire logic [7:0]              rd_data
);

    localparam int FCW = $clog2(FILT_LEN + 1);
    localparam logic [FCW-1:0] FILT_TOP = FCW'(FILT_LEN - 1);

    if (FILT_LEN < 1 || FILT_LEN > rtcsp_pkg::FILT_MAXC) begin : g_bad_filt
        $error("FILT_LEN out of range");
    end

    // The pointer logic and its wrap are sized for the 64-entry space only
    if (rtcsp_pkg::PTR_W != 6) begin : g_bad_ptr
        $error("PTR_W must match the 64-entry pointer space");
    end

    // The acknowledge slot must sit directly before the end of the frame
    if (rtcsp_pkg::BIT_END != rtcsp_pkg::BIT_ACK + 4'h1) begin : g_bad_slot
        $error("BIT_END must follow BIT_ACK");
    end

    // Address decode kept in one place so the direction bit is never compared
    function automatic logic own_addr(input logic [7:0] b);
        own_addr = b[7:1] == rtcsp_pkg::OWN_ADDR;
    endfunction

    function automatic logic [5:0] ptr_next(input logic [5:0] p);
        if (p == rtcsp_pkg::PTR_LAST) begin
            ptr_next = rtcsp_pkg::PTR_FIRST;
        end else begin
            ptr_next = p + 6'h01;
        end
    endfunction

    // Link-side reset, carried over as a level
    logic [1:0] lrst_sync;
    logic       link_rst_n;

    always_ff @(posedge link_clk) begin
        lrst_sync <= {lrst_sync[0], reset_n};
    end
    assign link_rst_n = lrst_sync[1];

    // Pin synchronisers and glitch filters
    logic [rtcsp_pkg::PIN_COUNT-1:0] pin_in;
    logic [rtcsp_pkg::PIN_COUNT-1:0] pin_f;

    assign pin_in = {sda_i, scl_i};

    for (genvar g = 0; g < rtcsp_pkg::PIN_COUNT; g++) begin : g_pin
        logic           s1;
        logic           s2;
        logic           f;
        logic [FCW-1:0] cnt;

        // A level must hold FILT_LEN samples before it is believed
        always_ff @(posedge link_clk) begin
            if (!link_rst_n) begin
                s1  <= 1'b1;
                s2  <= 1'b1;
                f   <= 1'b1;
                cnt <= '0;
            end else begin
                s1 <= pin_in[g];
                s2 <= s1;
                if (s2 == f) begin
                    cnt <= '0;
                end else if (cnt == FILT_TOP) begin
                    f   <= s2;
                    cnt <= '0;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
        assign pin_f[g] = f;
    end

    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;

    assign scl_f = pin_f[rtcsp_pkg::PIN_SCL];
    assign sda_f = pin_f[rtcsp_pkg::PIN_SDA];

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_f & ~scl_q;
    assign scl_fall  = ~scl_f & scl_q;
    assign bus_start = scl_f & scl_q & sda_q & ~sda_f;
    assign bus_stop  = scl_f & scl_q & ~sda_q & sda_f;

    // Byte fetched from the register side
    logic [2:0] dat_sync;
    logic [7:0] tx_buf;
    logic [7:0] rd_hold;
    logic       dat_tgl;

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            dat_sync <= '0;
            tx_buf   <= '0;
        end else begin
            dat_sync <= {dat_sync[1:0], dat_tgl};
            if (dat_sync[2] != dat_sync[1]) begin
                tx_buf <= rd_hold;
            end
        end
    end

    // Serial engine; SCL is only ever observed, never driven
    rtcsp_pkg::rtcsp_state_t state;
    logic [3:0]              bit_cnt;
    logic [7:0]              rx_shift;
    logic [7:0]              tx_shift;
    logic [5:0]              ptr;
    logic                    rw;
    logic                    nack;
    rtcsp_pkg::rtcsp_wr_t    wr_hold;
    logic                    wr_tgl;
    logic [5:0]              fetch_addr;
    logic                    fetch_tgl;
    logic                    ack_slot;
    logic                    end_slot;
    logic                    in_frame;

    assign ack_slot = bit_cnt == rtcsp_pkg::BIT_ACK;
    assign end_slot = bit_cnt == rtcsp_pkg::BIT_END;
    // Idle and ignore both leave SDA to the other parties
    assign in_frame = state != rtcsp_pkg::ST_IDLE && state != rtcsp_pkg::ST_IGNORE;

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            state      <= rtcsp_pkg::ST_IDLE;
            bit_cnt    <= rtcsp_pkg::BIT_FIRST;
            rx_shift   <= '0;
            tx_shift   <= '0;
            ptr        <= rtcsp_pkg::PTR_FIRST;
            rw         <= 1'b0;
            nack       <= 1'b0;
            wr_hold    <= '0;
            wr_tgl     <= 1'b0;
            fetch_addr <= rtcsp_pkg::PTR_FIRST;
            fetch_tgl  <= 1'b0;
            sda_oe     <= 1'b0;
            sda_o      <= 1'b0;
        end else if (bus_start) begin
            state   <= rtcsp_pkg::ST_ADDR;
            bit_cnt <= rtcsp_pkg::BIT_FIRST;
            sda_oe  <= 1'b0;
        end else if (bus_stop) begin
            state  <= rtcsp_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else if (!in_frame) begin
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            if (bit_cnt < rtcsp_pkg::BIT_END) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (bit_cnt < rtcsp_pkg::BIT_ACK) begin
                rx_shift <= {rx_shift[6:0], sda_f};
            end
            if (ack_slot && state == rtcsp_pkg::ST_RDATA) begin
                nack <= sda_f;
                ptr  <= ptr_next(ptr);
                if (!sda_f) begin
                    fetch_addr <= ptr_next(ptr);
                    fetch_tgl  <= ~fetch_tgl;
                end
            end
        end else if (scl_fall) begin
            if (ack_slot) begin
                case (state)
                    rtcsp_pkg::ST_ADDR: begin
                        if (own_addr(rx_shift)) begin
                            sda_oe <= 1'b1;
                            rw     <= rx_shift[0];
                            if (rx_shift[0] == rtcsp_pkg::DIR_READ) begin
                                fetch_addr <= ptr;
                                fetch_tgl  <= ~fetch_tgl;
                            end
                        end else begin
                            state <= rtcsp_pkg::ST_IGNORE;
                        end
                    end
                    rtcsp_pkg::ST_PTR: begin
                        ptr    <= rx_shift[5:0];
                        sda_oe <= 1'b1;
                    end
                    rtcsp_pkg::ST_WDATA: begin
                        wr_hold <= '{addr: ptr, data: rx_shift};
                        wr_tgl  <= ~wr_tgl;
                        ptr     <= ptr_next(ptr);
                        sda_oe  <= 1'b1;
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end else if (end_slot) begin
                bit_cnt <= rtcsp_pkg::BIT_FIRST;
                case (state)
                    rtcsp_pkg::ST_ADDR: begin
                        if (rw == rtcsp_pkg::DIR_READ) begin
                            state    <= rtcsp_pkg::ST_RDATA;
                            tx_shift <= tx_buf;
                            sda_oe   <= ~tx_buf[7];
                        end else begin
                            state  <= rtcsp_pkg::ST_PTR;
                            sda_oe <= 1'b0;
                        end
                    end
                    rtcsp_pkg::ST_PTR: begin
                        state  <= rtcsp_pkg::ST_WDATA;
                        sda_oe <= 1'b0;
                    end
                    rtcsp_pkg::ST_RDATA: begin
                        if (nack) begin
                            state  <= rtcsp_pkg::ST_IGNORE;
                            sda_oe <= 1'b0;
                        end else begin
                            tx_shift <= tx_buf;
                            sda_oe   <= ~tx_buf[7];
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end else if (state == rtcsp_pkg::ST_RDATA) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                sda_oe   <= ~tx_shift[6];
            end
        end
    end

    // Register side: toggles are held stable for a whole bit time, so words
    // carried beside them are safe to sample after the synchronised edge
    logic [2:0] wr_sync;
    logic [2:0] fetch_sync;
    logic       rd_cap;

    // Write events
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_sync  <= '0;
            wr_valid <= 1'b0;
            wr_evt   <= '0;
        end else begin
            wr_sync  <= {wr_sync[1:0], wr_tgl};
            wr_valid <= wr_sync[2] != wr_sync[1];
            if (wr_sync[2] != wr_sync[1]) begin
                wr_evt <= wr_hold;
            end
        end
    end

    // Fetch requests
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fetch_sync <= '0;
            rd_req     <= 1'b0;
            rd_addr    <= rtcsp_pkg::PTR_FIRST;
        end else begin
            fetch_sync <= {fetch_sync[1:0], fetch_tgl};
            rd_req     <= fetch_sync[2] != fetch_sync[1];
            if (fetch_sync[2] != fetch_sync[1]) begin
                rd_addr <= fetch_addr;
            end
        end
    end

    // Fixed one-cycle read latency; the byte goes back by toggle like the rest
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_cap  <= 1'b0;
            rd_hold <= '0;
            dat_tgl <= 1'b0;
        end else begin
            rd_cap <= rd_req;
            if (rd_cap) begin
                rd_hold <= rd_data;
                dat_tgl <= ~dat_tgl;
            end
        end
    end

endmodule

`default_nettype wire

// File: tb/rtcsp_master.sv
`timescale 1ns/1ns
`default_nettype none
module rtcsp_master (
    input  wire logic lclk,
    input  wire logic sda_in,
    output var logic  scl,
    output var logic  sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Quarter bit of 10 link cycles keeps well clear of the pin filter delay
    task automatic q;
        repeat (10) @(posedge lclk);
        #1;
    endtask
    task automatic start;
        sda = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda = 1'b0;
        q;
        scl = 1'b0;
        q;
    endtask
    task automatic stop;
        sda = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda = 1'b1;
        q;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda = b;
        q;
        scl = 1'b1;
        q;
        r = sda_in;
        q;
        scl = 1'b0;
        q;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            b = {b[6:0], r};
        end
        bit_io(!ack, r);
    endtask
endmodule
`default_nettype wire

// File: tb/rtcsp_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rtcsp_checker (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   link_clk,
    input wire logic                   scl_i,
    input wire logic                   sda_i,
    input wire logic                   sda_o,
    input wire logic                   sda_oe,
    input wire logic                   wr_valid,
    input wire rtcsp_pkg::rtcsp_wr_t   wr_evt,
    input wire logic                   rd_req,
    input wire logic [5:0]             rd_addr,
    input wire logic [7:0]             rd_data
);
    a_drive_low_only: assert property (@(posedge link_clk) disable iff (!reset_n)
        sda_oe |-> !sda_o) else $error("sda driven high");
    a_oe_change_low: assert property (@(posedge link_clk) disable iff (!reset_n)
        $changed(sda_oe) |-> !scl_i && !$past(scl_i, 2)) else $error("sda moved, scl high");
    a_ack_held_high: assert property (@(posedge link_clk) disable iff (!reset_n)
        sda_oe && $rose(scl_i) |-> sda_oe[*8]) else $error("low bit not held");
    a_start_released: assert property (@(posedge link_clk) disable iff (!reset_n)
        scl_i && $past(scl_i) && $fell(sda_i) |-> (!sda_oe)[*8]) else $error("driven at start");
    a_wr_gap: assert property (@(posedge clk) disable iff (!reset_n)
        wr_valid |=> (!wr_valid)[*8]) else $error("write pulses too close");
    a_rd_gap: assert property (@(posedge clk) disable iff (!reset_n)
        rd_req |=> (!rd_req)[*8]) else $error("fetch pulses too close");
    a_wr_evt_hold: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(wr_evt) |-> wr_valid) else $error("write event moved");
    a_rd_addr_hold: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(rd_addr) |-> rd_req) else $error("fetch address moved");
endmodule
bind rtcsp_slave rtcsp_checker u_rtcsp_checker (.clk(clk), .reset_n(reset_n),
    .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .wr_valid(wr_valid), .wr_evt(wr_evt), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data));
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] WADR = {rtcsp_pkg::OWN_ADDR, 1'b0};
    localparam logic [7:0] RADR = {rtcsp_pkg::OWN_ADDR, rtcsp_pkg::DIR_READ};
    logic                  clk, lclk, reset_n, scl, m_sda, sda_o, sda_oe, wr_valid, rd_req;
    logic [5:0]            rd_addr;
    logic [7:0]            rd_data = 8'h00;
    logic [7:0]            mem [64];
    rtcsp_pkg::rtcsp_wr_t  wr_evt;
    rtcsp_pkg::rtcsp_wr_t  wq [$];
    logic [5:0]            rq [$];
    int                    fail_count = 0;
    int                    checks = 0;
    // Wired-AND line with pull-up
    wire logic sda_line = m_sda & !(sda_oe & !sda_o);
    rtcsp_slave #(.FILT_LEN(1)) u_rtcsp_slave (.clk(clk), .reset_n(reset_n),
        .link_clk(lclk), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .wr_valid(wr_valid), .wr_evt(wr_evt), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_data(rd_data));
    rtcsp_master u_rtcsp_master (.lclk(lclk), .sda_in(sda_line), .scl(scl), .sda(m_sda));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3;
        forever #6 lclk = ~lclk;
    end
    always @(posedge clk) begin
        #1 rd_data = mem[rd_addr];
    end
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("Error %s expected %h got %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (reset_n && wr_valid === 1'b1) begin
            checks++;
            if (wq.size() == 0 || wr_evt !== wq[0]) begin
                $display("Error wr_evt expected %h got %h", wq.size() ? wq[0] : 14'h0, wr_evt);
                fail_count++;
            end
            if (wq.size() != 0) void'(wq.pop_front());
        end
    end
    always @(posedge clk) begin
        if (reset_n && rd_req === 1'b1) begin
            checks++;
            if (rq.size() == 0 || rd_addr !== rq[0]) begin
                $display("Error rd_addr expected %h got %h", rq.size() ? rq[0] : 6'h0, rd_addr);
                fail_count++;
            end
            if (rq.size() != 0) void'(rq.pop_front());
        end
    end
    initial begin
        #600000;
        fail_count++;
        $display("Error watchdog expected done got hang");
        summarize;
    end
    initial begin
        logic       a;
        logic [7:0] b, d;
        reset_n = 1'b0;
        void'($urandom(48777));
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (5) @(posedge clk);
        check("reset outs", 8'h00, {sda_oe, wr_valid, rd_req, rd_addr[4:0]});
        #1 reset_n = 1'b1;
        repeat (6) @(posedge lclk);
        // Burst write across the top of the pointer space
        u_rtcsp_master.start;
        u_rtcsp_master.wbyte(WADR, a); check("wr addr ack", 8'h01, 8'(a));
        u_rtcsp_master.wbyte(8'h3E, a); check("ptr ack", 8'h01, 8'(a));
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            wq.push_back({6'h3E + 6'(i), d});
            u_rtcsp_master.wbyte(d, a); check("data ack", 8'h01, 8'(a));
        end
        u_rtcsp_master.stop;
        // Pointer set, then repeated start into a read
        u_rtcsp_master.start;
        u_rtcsp_master.wbyte(WADR, a);
        u_rtcsp_master.wbyte(8'h3F, a);
        rq.push_back(6'h3F);
        rq.push_back(6'h00);
        u_rtcsp_master.start;
        u_rtcsp_master.wbyte(RADR, a); check("rd addr ack", 8'h01, 8'(a));
        u_rtcsp_master.rbyte(1'b1, b); check("rd byte0", mem[63], b);
        u_rtcsp_master.rbyte(1'b0, b); check("rd byte1", mem[0], b);
        check("release", 8'h00, 8'(sda_oe));
        u_rtcsp_master.stop;
        // Foreign address must be ignored
        u_rtcsp_master.start;
        u_rtcsp_master.wbyte({rtcsp_pkg::OWN_ADDR ^ 7'h01, 1'b0}, a);
        check("foreign ack", 8'h00, 8'(a));
        u_rtcsp_master.wbyte(8'hA5, a); check("ignored ack", 8'h00, 8'(a));
        u_rtcsp_master.stop;
        // Read with no pointer write resumes after the NACKed byte
        rq.push_back(6'h01);
        u_rtcsp_master.start;
        u_rtcsp_master.wbyte(RADR, a);
        u_rtcsp_master.rbyte(1'b0, b); check("rd resume", mem[1], b);
        u_rtcsp_master.stop;
        repeat (10) @(posedge clk);
        check("writes left", 8'h00, 8'(wq.size()));
        check("reads left", 8'h00, 8'(rq.size()));
        summarize;
    end
endmodule
`default_nettype wire
